//--- sps_chk_sva.sv
// assertion checker watching the sram pin bundle between the two ends
module sps_chk
    import sps_pkg::*;
(
    input wire logic      clk_sys,
    input wire logic      nrst,
    input wire logic      k_p,
    input wire logic      k_n,
    input wire logic      c_p,
    input wire logic      c_n,
    input wire logic      read_select_n,
    input wire logic      write_select_n,
    input wire sps_word_t q,
    input wire logic      q_oe,
    input wire logic      echo_clock_p,
    input wire logic      echo_clock_n,
    input wire logic      pll_enable_strap
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    // read timing: isolated reads only, back-to-back would keep q_oe high
    a_read_lat_pll: assert property ((k_p && !k_n && !read_select_n && pll_enable_strap)
        |-> ##4 q_oe ##1 q_oe) else $error("read data late or short");
    // pll mode launches half a k period later than legacy mode
    a_oe_cause: assert property ($rose(q_oe) |->
        (pll_enable_strap ? $past(!read_select_n, 4) : $past(!read_select_n, 3)))
        else $error("output enable without read request");
    a_oe_release: assert property ($rose(q_oe) |=> q_oe ##1 !q_oe)
        else $error("outputs not released after burst");
    // selects only ever low in the k rise cycle
    a_rsel_krise: assert property (!read_select_n |-> k_p && !k_n)
        else $error("read select outside k rise");
    a_wsel_krise: assert property (!write_select_n |-> k_p && !k_n)
        else $error("write select outside k rise");
    a_k_toggles: assert property ((k_p ^ k_n) |=> (k_p ^ k_n) && (k_p != $past(k_p)))
        else $error("input clock pair stalled");
    // output clocks both parked high mean single-clock mode: echoes follow k
    a_echo_tracks: assert property (echo_clock_p == ((c_p && c_n) ? k_p : c_p)
        && echo_clock_n == ((c_p && c_n) ? k_n : c_n))
        else $error("echo clocks off the output clocks");
    a_out_clk_pair: assert property ((c_p ^ c_n) |-> c_p == k_p)
        else $error("output clock pair skewed from input pair");
    a_reset_idle: assert property ($rose(nrst) |-> !q_oe && read_select_n && write_select_n)
        else $error("not idle after reset");
    // main scenarios
    c_read: cover property (!read_select_n && write_select_n);
    c_write: cover property (!write_select_n && read_select_n);
    c_both: cover property (!write_select_n && !read_select_n);
endmodule

//--- sps_ctrl.sv
// memory controller end: avalon-mm registers in, sram pins out
module sps_ctrl
    import sps_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    sps_if.ctl               lnk
);
    logic [1:0]  ctrl_q;
    sps_addr_t   addr_q;
    sps_word_t   wd0_q;
    sps_word_t   wd1_q;
    logic [3:0]  lanes_q;
    sps_word_t   rd0_q;
    sps_word_t   rd1_q;
    logic        rdv_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    sps_cst_e    st_q;
    logic [10:0] lock_cnt_q;
    logic        do_rd_q;
    logic        do_wr_q;
    logic        cap_q;
    logic        kp_q;
    logic        kn_q;
    logic        rs_n_q;
    logic        ws_n_q;
    sps_lane_t   lanes_n_q;
    sps_addr_t   pin_addr_q;
    sps_word_t   pin_d_q;
    logic        wr_acc;
    logic        go;
    logic [31:0] rmux;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, so read data comes from a flip-flop
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_acc          = avs_write & ack_q;
    assign go              = wr_acc && avs_address == `SPS_REG_CMD && st_q == ST_IDLE;
    assign avs_readdata    = rdata_q;

    always_comb begin
        unique case (avs_address)
            `SPS_REG_CTRL:   rmux = {30'h0, ctrl_q};
            `SPS_REG_ADDR:   rmux = {13'h0, addr_q};
            `SPS_REG_WDATA0: rmux = {14'h0, wd0_q};
            `SPS_REG_WDATA1: rmux = {14'h0, wd1_q};
            `SPS_REG_LANES:  rmux = {28'h0, lanes_q};
            `SPS_REG_STATUS: rmux = {29'h0, rdv_q, st_q != ST_LOCK, st_q != ST_IDLE};
            `SPS_REG_RDATA0: rmux = {14'h0, rd0_q};
            `SPS_REG_RDATA1: rmux = {14'h0, rd1_q};
            default:         rmux = 32'h0; // unmapped and cmd read as zero
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q   <= (avs_read | avs_write) & ~ack_q;
            rdata_q <= rmux;
        end
    end

    // software-written settings
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_q  <= `SPS_CTRL_RST;
            addr_q  <= '0;
            wd0_q   <= '0;
            wd1_q   <= '0;
            lanes_q <= `SPS_LANES_RST;
        end else if (wr_acc) begin
            if (avs_address == `SPS_REG_CTRL)   ctrl_q  <= avs_writedata[1:0];
            if (avs_address == `SPS_REG_ADDR)   addr_q  <= avs_writedata[`SPS_AW-1:0];
            if (avs_address == `SPS_REG_WDATA0) wd0_q   <= avs_writedata[`SPS_DW-1:0];
            if (avs_address == `SPS_REG_WDATA1) wd1_q   <= avs_writedata[`SPS_DW-1:0];
            if (avs_address == `SPS_REG_LANES)  lanes_q <= avs_writedata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input clock pair: parked high in reset, then free running at half rate
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            kp_q <= 1'b1;
            kn_q <= 1'b1;
        end else if (kp_q & kn_q) begin
            kp_q <= 1'b0;
        end else begin
            kp_q <= kn_q;
            kn_q <= kp_q;
        end
    end

    // output clocks held high select single-clock mode at power-on
    assign lnk.c_p              = ctrl_q[`SPS_CTRL_SINGLE] ? 1'b1 : kp_q;
    assign lnk.c_n              = ctrl_q[`SPS_CTRL_SINGLE] ? 1'b1 : kn_q;
    assign lnk.k_p              = kp_q;
    assign lnk.k_n              = kn_q;
    assign lnk.pll_enable_strap = ctrl_q[`SPS_CTRL_PLL];
    assign lnk.read_select_n    = rs_n_q;
    assign lnk.write_select_n   = ws_n_q;
    assign lnk.lane_write_select_n = lanes_n_q;
    assign lnk.addr             = pin_addr_q;
    assign lnk.d                = pin_d_q;

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencer
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_q       <= ST_LOCK;
            lock_cnt_q <= '0;
            do_rd_q    <= 1'b0;
            do_wr_q    <= 1'b0;
            cap_q      <= 1'b0;
            rs_n_q     <= 1'b1;
            ws_n_q     <= 1'b1;
            lanes_n_q  <= '1;
            pin_addr_q <= '0;
            pin_d_q    <= '0;
            rd0_q      <= '0;
            rd1_q      <= '0;
            rdv_q      <= 1'b0;
        end else begin
            unique case (st_q)
                ST_LOCK: begin
                    // no request until the pll has had its settling time
                    lock_cnt_q <= lock_cnt_q + 11'h1;
                    if (lock_cnt_q == 11'(`SPS_LOCK_CYC - 1)) st_q <= ST_IDLE;
                end
                ST_IDLE: if (go) begin
                    do_wr_q <= avs_writedata[`SPS_CMD_WR];
                    do_rd_q <= avs_writedata[`SPS_CMD_RD];
                    if (avs_writedata[`SPS_CMD_RD]) rdv_q <= 1'b0;
                    st_q <= ST_ALIGN;
                end
                ST_ALIGN: if (~kp_q & kn_q) begin
                    // present request for the coming k rise
                    rs_n_q     <= ~do_rd_q;
                    ws_n_q     <= ~do_wr_q;
                    pin_addr_q <= addr_q;
                    pin_d_q    <= wd0_q;
                    lanes_n_q  <= ~lanes_q[1:0];
                    st_q       <= ST_RISE;
                end
                ST_RISE: begin
                    // second word and write address for the k# rise
                    rs_n_q    <= 1'b1;
                    ws_n_q    <= 1'b1;
                    pin_d_q   <= wd1_q;
                    lanes_n_q <= ~lanes_q[3:2];
                    st_q      <= ST_FALL;
                end
                ST_FALL: begin
                    cap_q <= 1'b0;
                    st_q  <= do_rd_q ? ST_RDATA : ST_IDLE;
                end
                ST_RDATA: if (lnk.q_oe) begin
                    // the device marks its burst with the output enable
                    if (!cap_q) begin
                        rd0_q <= lnk.q;
                        cap_q <= 1'b1;
                    end else begin
                        rd1_q <= lnk.q;
                        rdv_q <= 1'b1;
                        st_q  <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- sps_dev.sv
// separate read/write port ddr burst sram, two-word bursts
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
module sps_dev
    import sps_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic nrst,
    sps_if.dev        lnk,
    output logic      pll_locked,
    output logic      single_clock_mode,
    output logic      impedance_update
);
    localparam int LANE_W = `SPS_DW / `SPS_LW;

    logic                   kp_q;
    logic                   kn_q;
    logic                   op_q;
    logic                   on_q;
    logic                   strap_done_q;
    logic                   single_q;
    logic                   pll_on_q;
    logic                   single_now;
    logic                   oc_p;
    logic                   oc_n;
    logic                   kr;
    logic                   kfr;
    logic                   opr;
    logic                   onr;
    logic [2*`SPS_DW-1:0]   mem_q [0:(1<<`SPS_AW)-1];
    logic                   wr_pend_q;
    sps_word_t              wr_w0_q;
    sps_lane_t              wr_l0_q;
    logic                   commit;
    logic [2*`SPS_DW-1:0]   wr_new;
    logic                   rd_a_v_q;
    sps_addr_t              rd_a_addr_q;
    logic                   armed_q;
    sps_addr_t              rd_b_addr_q;
    sps_addr_t              rd_src;
    logic [2*`SPS_DW-1:0]   rd_word;
    logic                   launch;
    logic                   w1_ev;
    sps_oph_e               ph_q;
    sps_word_t              q_q;
    sps_word_t              hold1_q;
    logic                   oe_q;
    logic [9:0]             zq_cnt_q;
    logic                   zq_pulse_q;
    logic [10:0]            lock_cnt_q;
    logic [1:0]             idle_cnt_q;

    // replace only the lanes whose select is active
    function automatic sps_word_t lane_merge(sps_word_t old_w, sps_word_t new_w,
                                             sps_lane_t en);
        sps_word_t r;
        r = old_w;
        for (int i = 0; i < `SPS_LW; i++) begin
            if (en[i]) r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // straps: caught on the first clock after reset, fixed afterwards
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            strap_done_q <= 1'b0;
            single_q     <= 1'b0;
            pll_on_q     <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            single_q     <= lnk.c_p & lnk.c_n;
            pll_on_q     <= lnk.pll_enable_strap;
        end
    end

    // single-clock mode borrows the input pair as output clocks; until the
    // strap is caught the live pins decide, so echoes never run off the wrong pair
    assign single_now = strap_done_q ? single_q : (lnk.c_p & lnk.c_n);
    assign oc_p = single_now ? lnk.k_p : lnk.c_p;
    assign oc_n = single_now ? lnk.k_n : lnk.c_n;

    // previous clock levels reset high, the parked state, so no false rise
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            kp_q <= 1'b1;
            kn_q <= 1'b1;
            op_q <= 1'b1;
            on_q <= 1'b1;
        end else begin
            kp_q <= lnk.k_p;
            kn_q <= lnk.k_n;
            op_q <= oc_p;
            on_q <= oc_n;
        end
    end

    // nothing is accepted before the straps are known
    assign kr  = lnk.k_p & ~kp_q & strap_done_q;
    assign kfr = lnk.k_n & ~kn_q & strap_done_q;
    assign opr = oc_p & ~op_q;
    assign onr = oc_n & ~on_q;

    ////////////////////////////////////////////////////////////////////////
    // write port: word one at k rise, address and word two at k# rise
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_pend_q <= 1'b0;
            wr_w0_q   <= '0;
            wr_l0_q   <= '0;
        end else if (kr && !lnk.write_select_n) begin
            wr_pend_q <= 1'b1;
            wr_w0_q   <= lnk.d;
            wr_l0_q   <= ~lnk.lane_write_select_n;
        end else if (kfr) begin
            // a deselect only stops new writes, the pending one still lands
            wr_pend_q <= 1'b0;
        end
    end

    // a location holds the word pair: low half is a+0, high half a+1
    assign commit = kfr & wr_pend_q;
    assign wr_new = {lane_merge(mem_q[lnk.addr][2*`SPS_DW-1:`SPS_DW], lnk.d,
                                ~lnk.lane_write_select_n),
                     lane_merge(mem_q[lnk.addr][`SPS_DW-1:0], wr_w0_q,
                                wr_l0_q)};

    // array storage, no reset: contents are undefined after power-up
    always_ff @(posedge clk_sys) begin
        if (commit) mem_q[lnk.addr] <= wr_new;
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: address latched at k rise, burst launched a cycle later
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rd_a_v_q    <= 1'b0;
            rd_a_addr_q <= '0;
        end else if (kr) begin
            rd_a_v_q    <= ~lnk.read_select_n;
            rd_a_addr_q <= lnk.addr;
        end
    end

    // pll mode waits for the output clock fall half way through t+1
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            armed_q     <= 1'b0;
            rd_b_addr_q <= '0;
        end else if (pll_on_q && kr && rd_a_v_q) begin
            armed_q     <= 1'b1;
            rd_b_addr_q <= rd_a_addr_q;
        end else if (launch) begin
            armed_q     <= 1'b0;
        end
    end

    // the array is read at launch so that a write committing on the
    // same edge is forwarded rather than missed
    assign rd_src  = pll_on_q ? rd_b_addr_q : rd_a_addr_q;
    assign rd_word = (commit && lnk.addr == rd_src) ? wr_new : mem_q[rd_src];
    assign launch  = pll_on_q ? (onr & armed_q) : (kr & rd_a_v_q);
    assign w1_ev   = pll_on_q ? opr : onr;

    ////////////////////////////////////////////////////////////////////////
    // output register: word a+0, word a+1, then float on the next edge
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q_q     <= '0;
            hold1_q <= '0;
            oe_q    <= 1'b0;
            ph_q    <= OPH_IDLE;
        end else if (launch) begin
            q_q     <= rd_word[`SPS_DW-1:0];
            hold1_q <= rd_word[2*`SPS_DW-1:`SPS_DW];
            oe_q    <= 1'b1;
            ph_q    <= OPH_W1;
        end else if (ph_q == OPH_W1 && w1_ev) begin
            q_q     <= hold1_q;
            ph_q    <= OPH_TAIL;
        end else if (ph_q == OPH_TAIL && (opr || onr)) begin
            // no turnaround gap needed between banked parts
            oe_q    <= 1'b0;
            ph_q    <= OPH_IDLE;
        end
    end

    assign lnk.q            = q_q;
    assign lnk.q_oe         = oe_q;
    assign lnk.echo_clock_p = oc_p;
    assign lnk.echo_clock_n = oc_n;

    ////////////////////////////////////////////////////////////////////////
    // periodic driver impedance update
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            zq_cnt_q   <= '0;
            zq_pulse_q <= 1'b0;
        end else begin
            zq_cnt_q   <= zq_cnt_q + 10'h1; // wraps at the period
            zq_pulse_q <= zq_cnt_q == 10'(`SPS_ZQ_CYC - 1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pll lock: counts stable clock, a stopped k restarts the count
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            idle_cnt_q <= '0;
        end else if (lnk.k_p != kp_q) begin
            idle_cnt_q <= '0;
        end else if (idle_cnt_q != 2'(`SPS_STOP_CYC)) begin
            idle_cnt_q <= idle_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            lock_cnt_q <= '0;
        end else if (idle_cnt_q == 2'(`SPS_STOP_CYC)) begin
            lock_cnt_q <= '0;
        end else if (lock_cnt_q != 11'(`SPS_LOCK_CYC)) begin
            lock_cnt_q <= lock_cnt_q + 11'h1;
        end
    end

    // legacy mode has no pll, so it never reports lock
    assign pll_locked        = pll_on_q & (lock_cnt_q == 11'(`SPS_LOCK_CYC));
    assign single_clock_mode = single_q;
    assign impedance_update  = zq_pulse_q;
endmodule

//--- sps_if.sv
// pin bundle between the burst sram and its memory controller
interface sps_if;
    import sps_pkg::*;
    logic      k_p;
    logic      k_n;
    logic      c_p;
    logic      c_n;
    logic      read_select_n;
    logic      write_select_n;
    sps_lane_t lane_write_select_n;
    sps_addr_t addr;
    sps_word_t d;
    sps_word_t q;
    logic      q_oe;
    logic      echo_clock_p;
    logic      echo_clock_n;
    logic      pll_enable_strap;

    modport dev (
        input  k_p, k_n, c_p, c_n, read_select_n, write_select_n,
        input  lane_write_select_n, addr, d, pll_enable_strap,
        output q, q_oe, echo_clock_p, echo_clock_n
    );
    modport ctl (
        output k_p, k_n, c_p, c_n, read_select_n, write_select_n,
        output lane_write_select_n, addr, d, pll_enable_strap,
        input  q, q_oe, echo_clock_p, echo_clock_n
    );
endinterface

//--- sps_map.svh
// constants for the separate-port burst sram and its controller
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
`define SPS_AW          19
`define SPS_DW          18
`define SPS_LW          2
`define SPS_CLK_MHZ     50
`define SPS_ZQ_CYC      1024
`define SPS_LOCK_US     20
`define SPS_LOCK_CYC    (`SPS_LOCK_US * `SPS_CLK_MHZ)
`define SPS_STOP_NS     30
`define SPS_STOP_CYC    ((`SPS_STOP_NS * `SPS_CLK_MHZ + 999) / 1000)
// controller register byte offsets
`define SPS_REG_CTRL    6'h00
`define SPS_REG_ADDR    6'h04
`define SPS_REG_WDATA0  6'h08
`define SPS_REG_WDATA1  6'h0C
`define SPS_REG_LANES   6'h10
`define SPS_REG_CMD     6'h14
`define SPS_REG_STATUS  6'h18
`define SPS_REG_RDATA0  6'h1C
`define SPS_REG_RDATA1  6'h20
// field positions and reset values
`define SPS_CTRL_PLL    0
`define SPS_CTRL_SINGLE 1
`define SPS_CTRL_RST    2'h1
`define SPS_LANES_RST   4'hF
`define SPS_CMD_WR      0
`define SPS_CMD_RD      1
`define SPS_STAT_BUSY   0
`define SPS_STAT_READY  1
`define SPS_STAT_RDV    2
`endif

//--- sps_pkg.sv
// types shared by the sram model and its controller
`include "sps_map.svh"
package sps_pkg;
    typedef logic [`SPS_AW-1:0] sps_addr_t;
    typedef logic [`SPS_DW-1:0] sps_word_t;
    typedef logic [`SPS_LW-1:0] sps_lane_t;
    typedef enum logic [1:0] {OPH_IDLE, OPH_W1, OPH_TAIL} sps_oph_e;
    typedef enum logic [2:0] {ST_LOCK, ST_IDLE, ST_ALIGN, ST_RISE, ST_FALL, ST_RDATA} sps_cst_e;
endpackage

//--- tb_sep_port_ddr_burst2_sram.sv
// self-checking bench: controller and sram joined pin to pin, driven over avalon
`include "sps_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_sep_port_ddr_burst2_sram
    import sps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        nrst_dev = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pll_locked;
    logic        single_clock_mode;
    logic        impedance_update;
    int          failures = 0;
    int          n_tests = 0;
    sps_if lnk ();
    sps_ctrl i_sps_ctrl (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lnk(lnk));
    sps_dev i_sps_dev (.clk_sys(clk_sys), .nrst(nrst_dev), .lnk(lnk), .pll_locked(pll_locked),
        .single_clock_mode(single_clock_mode), .impedance_update(impedance_update));
    sps_chk i_sps_chk (.clk_sys(clk_sys), .nrst(nrst), .k_p(lnk.k_p), .k_n(lnk.k_n),
        .c_p(lnk.c_p), .c_n(lnk.c_n), .read_select_n(lnk.read_select_n),
        .write_select_n(lnk.write_select_n), .q(lnk.q), .q_oe(lnk.q_oe),
        .echo_clock_p(lnk.echo_clock_p), .echo_clock_n(lnk.echo_clock_n),
        .pll_enable_strap(lnk.pll_enable_strap));
    always #10 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    // one avalon access; request held until waitrequest is seen low at an edge
    task automatic av_xfer(input logic [5:0] a, input logic wr, input logic [31:0] wd,
                           output logic [31:0] rd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        // only the watchdog ends a wait that never gets an answer
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // a spare edge so the next access never re-drives in the same step
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        logic [31:0] dummy;
        av_xfer(a, 1'b1, v, dummy);
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        av_xfer(a, 1'b0, 32'h0, v);
    endtask
    // poll a status bit; bounded so a stuck controller counts a failure instead of hanging
    task automatic wait_stat(input int b, input logic lvl);
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            rd(`SPS_REG_STATUS, s);
            n++;
        end while (s[b] !== lvl && n < 1000);
        if (s[b] !== lvl) failures++;
    endtask
    task automatic mem_wr(input sps_addr_t a, input sps_word_t w0, w1, input logic [3:0] l);
        wr(`SPS_REG_ADDR, {13'h0, a});
        wr(`SPS_REG_WDATA0, {14'h0, w0});
        wr(`SPS_REG_WDATA1, {14'h0, w1});
        wr(`SPS_REG_LANES, {28'h0, l});
        wr(`SPS_REG_CMD, 32'h1);
        wait_stat(`SPS_STAT_BUSY, 1'b0);
    endtask
    task automatic mem_rd(input sps_addr_t a, input logic [31:0] cmd, output sps_word_t r0, r1);
        logic [31:0] v;
        wr(`SPS_REG_ADDR, {13'h0, a});
        wr(`SPS_REG_CMD, cmd);
        wait_stat(`SPS_STAT_RDV, 1'b1);
        rd(`SPS_REG_RDATA0, v);
        r0 = v[17:0];
        rd(`SPS_REG_RDATA1, v);
        r1 = v[17:0];
    endtask
    task automatic do_reset;
        logic [31:0] v;
        nrst <= 1'b0;
        nrst_dev <= 1'b0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        nrst_dev <= 1'b1;
        @(posedge clk_sys);
        `CHK(lnk.q_oe, 1'b0)
        `CHK(single_clock_mode, 1'b0)
        `CHK(pll_locked, 1'b0)
        rd(`SPS_REG_CTRL, v);
        `CHK(v, {30'h0, `SPS_CTRL_RST})
        rd(`SPS_REG_LANES, v);
        `CHK(v, {28'h0, `SPS_LANES_RST})
        rd(6'h3C, v);
        `CHK(v, 32'h0)
        wait_stat(`SPS_STAT_READY, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // full bursts at the array ends and middle, all written before any read back
    task automatic t_rw;
        sps_addr_t a [3] = '{19'h00000, 19'h7FFFF, 19'h2AAAA};
        sps_word_t r0, r1;
        for (int i = 0; i < 3; i++) mem_wr(a[i], a[i][17:0] ^ 18'h15A5A, ~a[i][17:0], 4'hF);
        `CHK(pll_locked, 1'b1)
        for (int i = 0; i < 3; i++) begin
            mem_rd(a[i], 32'h2, r0, r1);
            `CHK(r0, a[i][17:0] ^ 18'h15A5A)
            `CHK(r1, ~a[i][17:0])
        end
    endtask
    // lane selects merge new halves into what the array already holds
    task automatic t_lanes;
        logic [3:0] lt [4] = '{4'h0, 4'h9, 4'h6, 4'h5};
        sps_word_t e0, e1, n0, n1, r0, r1;
        e0 = 18'h3FFFF;
        e1 = 18'h3FFFF;
        mem_wr(19'h00100, e0, e1, 4'hF);
        for (int i = 0; i < 4; i++) begin
            n0 = 18'h12345 ^ 18'(i);
            n1 = 18'h0ABCD ^ 18'(i << 4);
            mem_wr(19'h00100, n0, n1, lt[i]);
            if (lt[i][0]) e0[8:0] = n0[8:0];
            if (lt[i][1]) e0[17:9] = n0[17:9];
            if (lt[i][2]) e1[8:0] = n1[8:0];
            if (lt[i][3]) e1[17:9] = n1[17:9];
            mem_rd(19'h00100, 32'h2, r0, r1);
            `CHK(r0, e0)
            `CHK(r1, e1)
        end
    endtask
    // read and write of one address started together return the new burst
    task automatic t_concurrent;
        sps_word_t r0, r1;
        mem_wr(19'h01234, 18'h11111, 18'h22222, 4'hF);
        wr(`SPS_REG_WDATA0, 32'h0003_3333);
        wr(`SPS_REG_WDATA1, 32'h0000_4444);
        mem_rd(19'h01234, 32'h3, r0, r1);
        `CHK(r0, 18'h33333)
        `CHK(r1, 18'h04444)
    endtask
    // spacing between two impedance updates, counted in clock cycles
    task automatic t_impedance;
        int n;
        n = 0;
        do @(posedge clk_sys); while (impedance_update !== 1'b1 && ++n < 1100);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (impedance_update !== 1'b1 && n < 1100);
        `CHK(n, `SPS_ZQ_CYC)
    endtask
    // straps written through ctrl while the sram is still held in reset
    task automatic t_strap(input logic [1:0] m);
        sps_word_t r0, r1;
        nrst <= 1'b0;
        nrst_dev <= 1'b0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        wr(`SPS_REG_CTRL, {30'h0, m});
        nrst_dev <= 1'b1;
        wait_stat(`SPS_STAT_READY, 1'b1);
        `CHK(single_clock_mode, m[`SPS_CTRL_SINGLE])
        mem_wr(19'h0BEEF, 18'h2D2D2, 18'h1E1E1, 4'hF);
        mem_rd(19'h0BEEF, 32'h2, r0, r1);
        `CHK(r0, 18'h2D2D2)
        `CHK(r1, 18'h1E1E1)
        `CHK(pll_locked, m[`SPS_CTRL_PLL])
    endtask
    task automatic end_sim;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence, with three more resets in mid-run
    initial begin
        do_reset();
        t_rw();
        t_lanes();
        t_concurrent();
        t_impedance();
        t_strap(2'h0);
        t_strap(2'h3);
        do_reset();
        t_concurrent();
        end_sim();
    end
    // watchdog sized well above the expected few thousand cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        end_sim();
    end
endmodule
